/* hdl/protect_defines.vh */
`ifndef PROTECT_DEFINES_VH
`define PROTECT_DEFINES_VH

// register indices on the plain register port
`define REG_SWITCH      3'h0
`define REG_ENPOL       3'h1
`define REG_GAINDEB     3'h2
`define REG_PATHEN      3'h3
`define REG_DAC         3'h4
`define REG_AMPTRIM     3'h5
`define REG_CMPTRIM     3'h6

// reset values
`define RST_SWITCH      8'hC8
`define RST_ENPOL       8'h00
`define RST_GAINDEB     8'h00
`define RST_PATHEN      8'h00
`define RST_DAC         8'h00
`define RST_AMPTRIM     8'h20
`define RST_CMPTRIM     8'h10

// field positions in enable_polarity_select
`define ENPOL_EN        7
`define ENPOL_HYST      6
`define ENPOL_DEB_OUT   5
`define ENPOL_POL       4
`define ENPOL_CPS       1
`define ENPOL_VRS       0

// field positions in gain_debounce_select
`define GD_DOUBLE       6
`define GD_GAIN_HI      5
`define GD_GAIN_LO      3
`define GD_DEB_HI       2
`define GD_DEB_LO       0

// field positions in signal_path_enables
`define PE_VIN          7
`define PE_CI2          6
`define PE_CI1          5
`define PE_CI0          4
`define PE_AMP_OUT      1
`define PE_CMP_OUT      0

// writable masks
`define MASK_ENPOL      8'hD3
`define MASK_GAINDEB    8'h7F
`define MASK_PATHEN     8'hF3
`define MASK_CMPTRIM    8'h7F

// debounce code width and stable counter width
`define DEB_CODE_W      3
`define DEB_CNT_W       8

`endif

/* hdl/compare_debounce.v */
`timescale 1ns/100ps
`include "protect_defines.vh"

module compare_debounce #(
    parameter CNT_W = `DEB_CNT_W
) (
    // clock and reset
    input  wire                    clk,
    input  wire                    srst,
    // control
    input  wire [`DEB_CODE_W-1:0]  debounce_code,
    // comparator
    input  wire                    raw_in,
    output reg                     filt_ff
);

    reg              last_ff;
    reg  [CNT_W-1:0] cnt_ff;
    reg  [CNT_W-1:0] limit;

    // code n>0 needs 2^n stable samples after the change sample: 2^n..2^n+1 periods; code 0 passes raw_in straight through
    always @* begin
        limit = ({{(CNT_W-1){1'b0}}, 1'b1} << debounce_code) - {{(CNT_W-1){1'b0}}, 1'b1};
    end

    always @(posedge clk) begin
        if (srst) begin
            last_ff <= 1'b0;
            cnt_ff  <= {CNT_W{1'b0}};
            filt_ff <= 1'b0;
        end else begin
            last_ff <= raw_in;
            if (debounce_code == {`DEB_CODE_W{1'b0}}) begin
                filt_ff <= raw_in;
                cnt_ff  <= {CNT_W{1'b0}};
            end else if (raw_in != last_ff) begin
                cnt_ff <= {CNT_W{1'b0}};
            end else if (cnt_ff < limit) begin
                cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                filt_ff <= last_ff;
            end
        end
    end

endmodule

/* hdl/overcurrent_protect_ctrl.v */
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "protect_defines.vh"

module overcurrent_protect_ctrl #(
    parameter DEB_W = `DEB_CNT_W
) (
    // clock and reset
    input  wire        clk,
    input  wire        srst,
    // register port
    input  wire [2:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_ff,
    // comparator from the analog side
    input  wire        comparator_in,
    // analog controls
    output reg  [7:0]  analog_switch_bits_ff,
    output reg  [7:0]  gain_ratio_ff,
    output reg         unity_buffer_ff,
    output reg  [7:0]  dac_code_ff,
    output reg         dac_reference_sel_ff,
    output reg         comparator_hysteresis_en_ff,
    output reg         comparator_input_sel_ff,
    output reg         voltage_input_en_ff,
    output reg  [2:0]  current_input_en_ff,
    output reg         amp_output_en_ff,
    output reg         comparator_output_en_ff,
    output reg         amp_trim_mode_ff,
    output reg         amp_trim_ref_sel_ff,
    output reg  [5:0]  amp_trim_value_ff,
    output reg         comparator_trim_mode_ff,
    output reg         comparator_trim_ref_sel_ff,
    output reg  [4:0]  comparator_trim_value_ff,
    // protection status
    output reg         raw_compare_out_ff,
    output reg         debounced_compare_out_ff,
    output reg         protect_irq_signal_ff,
    output reg         protect_irq_req_ff
);

    reg  [7:0] switch_ff;
    reg  [7:0] enpol_ff;
    reg  [7:0] gaindeb_ff;
    reg  [7:0] pathen_ff;
    reg  [7:0] dac_ff;
    reg  [7:0] amptrim_ff;
    reg  [6:0] cmptrim_ff;
    reg  [7:0] nxt_rdata;
    reg  [6:0] base_ratio;
    reg  [7:0] nxt_switch;
    reg        nxt_irq_signal;

    // named copies so the trim reset values can be sliced to field width
    localparam [7:0] AMPTRIM_RST = `RST_AMPTRIM;
    localparam [7:0] CMPTRIM_RST = `RST_CMPTRIM;

    wire       unit_enable = enpol_ff[`ENPOL_EN];
    wire       deb_out;
    wire [2:0] gain_code   = gaindeb_ff[`GD_GAIN_HI:`GD_GAIN_LO];

    // comparator must go through a disabled unit as zero, so filter sees zero too
    compare_debounce #(
        .CNT_W         (DEB_W)
    ) u_debounce (
        .clk           (clk),
        .srst          (srst),
        .debounce_code (gaindeb_ff[`GD_DEB_HI:`GD_DEB_LO]),
        .raw_in        (raw_compare_out_ff),
        .filt_ff       (deb_out)
    );

    // register writes
    always @(posedge clk) begin
        if (srst) begin
            switch_ff  <= `RST_SWITCH;
            enpol_ff   <= `RST_ENPOL;
            gaindeb_ff <= `RST_GAINDEB;
            pathen_ff  <= `RST_PATHEN;
            dac_ff     <= `RST_DAC;
            amptrim_ff <= `RST_AMPTRIM;
            cmptrim_ff <= CMPTRIM_RST[6:0];
        end else if (reg_wr) begin
            case (reg_addr)
                `REG_SWITCH:  switch_ff  <= reg_wdata;
                `REG_ENPOL:   enpol_ff   <= reg_wdata & `MASK_ENPOL;
                `REG_GAINDEB: gaindeb_ff <= reg_wdata & `MASK_GAINDEB;
                `REG_PATHEN:  pathen_ff  <= reg_wdata & `MASK_PATHEN;
                `REG_DAC:     dac_ff     <= reg_wdata;
                `REG_AMPTRIM: amptrim_ff <= reg_wdata;
                `REG_CMPTRIM: cmptrim_ff <= reg_wdata[6:0];
                default: begin
                end
            endcase
        end
    end

    // read mux; raw and debounced bits are live status
    always @* begin
        case (reg_addr)
            `REG_SWITCH:  nxt_rdata = switch_ff;
            `REG_ENPOL:   nxt_rdata = {enpol_ff[7:6], debounced_compare_out_ff, enpol_ff[4:0]};
            `REG_GAINDEB: nxt_rdata = {1'b0, gaindeb_ff[6:0]};
            `REG_PATHEN:  nxt_rdata = pathen_ff;
            `REG_DAC:     nxt_rdata = dac_ff;
            `REG_AMPTRIM: nxt_rdata = amptrim_ff;
            `REG_CMPTRIM: nxt_rdata = {raw_compare_out_ff, cmptrim_ff};
            default:      nxt_rdata = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end else begin
            reg_rdata_ff <= 8'h00;
        end
    end

    // ratio table, kept as a code so the analog side has no decode of its own
    always @* begin
        case (gain_code)
            3'h0:    base_ratio = 7'h01;
            3'h1:    base_ratio = 7'h04;
            3'h2:    base_ratio = 7'h06;
            3'h3:    base_ratio = 7'h0A;
            3'h4:    base_ratio = 7'h0F;
            3'h5:    base_ratio = 7'h19;
            3'h6:    base_ratio = 7'h28;
            3'h7:    base_ratio = 7'h41;
            default: base_ratio = 7'h01;
        endcase
    end

    // S6..S4 all open means follower: force them open internally
    always @* begin
        nxt_switch = switch_ff;
        if (switch_ff[6:4] == 3'h0) begin
            nxt_switch[6:4] = 3'h0;
        end
    end

    // polarity: 0 flags a rise of the filtered output, 1 flags a fall
    always @* begin
        nxt_irq_signal = enpol_ff[`ENPOL_POL] ? ~deb_out : deb_out;
    end

    // analog controls and status, all registered
    always @(posedge clk) begin
        if (srst) begin
            analog_switch_bits_ff       <= `RST_SWITCH;
            gain_ratio_ff               <= 8'h01;
            unity_buffer_ff             <= 1'b0;
            dac_code_ff                 <= `RST_DAC;
            dac_reference_sel_ff        <= 1'b0;
            comparator_hysteresis_en_ff <= 1'b0;
            comparator_input_sel_ff     <= 1'b0;
            voltage_input_en_ff         <= 1'b0;
            current_input_en_ff         <= 3'h0;
            amp_output_en_ff            <= 1'b0;
            comparator_output_en_ff     <= 1'b0;
            amp_trim_mode_ff            <= 1'b0;
            amp_trim_ref_sel_ff         <= 1'b0;
            amp_trim_value_ff           <= AMPTRIM_RST[5:0];
            comparator_trim_mode_ff     <= 1'b0;
            comparator_trim_ref_sel_ff  <= 1'b0;
            comparator_trim_value_ff    <= CMPTRIM_RST[4:0];
            raw_compare_out_ff          <= 1'b0;
            debounced_compare_out_ff    <= 1'b0;
            protect_irq_signal_ff       <= 1'b0;
            protect_irq_req_ff          <= 1'b0;
        end else begin
            analog_switch_bits_ff       <= nxt_switch;
            unity_buffer_ff             <= (switch_ff[6:4] == 3'h0);
            // doubled 65 needs the eighth bit
            gain_ratio_ff               <= gaindeb_ff[`GD_DOUBLE] ? {base_ratio, 1'b0}
                                                                  : {1'b0, base_ratio};
            dac_code_ff                 <= dac_ff;
            dac_reference_sel_ff        <= enpol_ff[`ENPOL_VRS];
            comparator_hysteresis_en_ff <= enpol_ff[`ENPOL_HYST];
            comparator_input_sel_ff     <= enpol_ff[`ENPOL_CPS];
            voltage_input_en_ff         <= unit_enable & pathen_ff[`PE_VIN];
            current_input_en_ff         <= {3{unit_enable}} & pathen_ff[`PE_CI2:`PE_CI0];
            amp_output_en_ff            <= unit_enable & pathen_ff[`PE_AMP_OUT];
            comparator_output_en_ff     <= unit_enable & pathen_ff[`PE_CMP_OUT];
            amp_trim_mode_ff            <= amptrim_ff[7];
            amp_trim_ref_sel_ff         <= amptrim_ff[6];
            amp_trim_value_ff           <= amptrim_ff[5:0];
            comparator_trim_mode_ff     <= cmptrim_ff[6];
            comparator_trim_ref_sel_ff  <= cmptrim_ff[5];
            comparator_trim_value_ff    <= cmptrim_ff[4:0];
            raw_compare_out_ff          <= unit_enable & comparator_in;
            debounced_compare_out_ff    <= deb_out;
            protect_irq_signal_ff       <= nxt_irq_signal;
            protect_irq_req_ff          <= nxt_irq_signal & ~protect_irq_signal_ff;
        end
    end

endmodule

/* bench/analog_side_model.sv */
`timescale 1ns/100ps

module analog_side_model #(
    parameter [5:0] AMP_OFFS = 6'h0D
) (
    // clock
    input  wire       clk,
    // controls from the block, sense level from the test
    input  wire       trim_mode,
    input  wire [5:0] trim_value,
    input  wire [7:0] dac_code,
    input  wire [7:0] sense_level,
    // comparator result
    output reg        cmp_out
);
    // fixed offset stands in for the silicon, so the sweep has one known flip point
    always @(posedge clk)
        cmp_out <= trim_mode ? (trim_value >= AMP_OFFS) : (sense_level > dac_code);
endmodule

/* bench/protect_sva.sv */
`timescale 1ns/100ps
`include "protect_defines.vh"

module protect_sva (
    // clock and reset
    input  wire       clk,
    input  wire       srst,
    // register port
    input  wire [2:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_rdata_ff,
    // controls and status
    input  wire [7:0] gain_ratio_ff,
    input  wire       voltage_input_en_ff,
    input  wire [2:0] current_input_en_ff,
    input  wire       amp_output_en_ff,
    input  wire       comparator_output_en_ff,
    input  wire       raw_compare_out_ff,
    input  wire       debounced_compare_out_ff,
    input  wire       protect_irq_signal_ff,
    input  wire       protect_irq_req_ff
);
    localparam [55:0] RATIOS = {7'h41, 7'h28, 7'h19, 7'h0F, 7'h0A, 7'h06, 7'h04, 7'h01};
    // shadows of written fields, the register bodies are not visible here
    reg        en_ff;
    reg        pol_ff;
    reg  [6:0] gd_ff;
    wire [6:0] base  = RATIOS[gd_ff[5:3]*7 +: 7];
    wire [7:0] ratio = gd_ff[6] ? {base, 1'b0} : {1'b0, base};
    always @(posedge clk)
        if (srst)
            {en_ff, pol_ff, gd_ff} <= 9'h000;
        else if (reg_wr && reg_addr == `REG_ENPOL)
            {en_ff, pol_ff} <= {reg_wdata[`ENPOL_EN], reg_wdata[`ENPOL_POL]};
        else if (reg_wr && reg_addr == `REG_GAINDEB)
            gd_ff <= reg_wdata[6:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_raw_off; !en_ff |=> !raw_compare_out_ff; endproperty
    a_raw_off: assert property (p_raw_off) else $error("raw flag while off");
    property p_amp_off; !en_ff |=> !amp_output_en_ff; endproperty
    a_amp_off: assert property (p_amp_off) else $error("amp out while off");
    property p_cmp_off; !en_ff |=> !comparator_output_en_ff; endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("cmp out while off");
    property p_in_off; !en_ff |=> !voltage_input_en_ff && current_input_en_ff == 3'h0; endproperty
    a_in_off: assert property (p_in_off) else $error("input on while off");
    property p_gain; gain_ratio_ff == $past(ratio); endproperty
    a_gain: assert property (p_gain) else $error("gain ratio wrong");
    property p_irq_sig; protect_irq_signal_ff == (debounced_compare_out_ff ^ $past(pol_ff)); endproperty
    a_irq_sig: assert property (p_irq_sig) else $error("irq level wrong");
    property p_irq_req; protect_irq_req_ff == (protect_irq_signal_ff && !$past(protect_irq_signal_ff)); endproperty
    a_irq_req: assert property (p_irq_req) else $error("irq pulse wrong");
    property p_rd_top; reg_rd && reg_addr == `REG_GAINDEB |=> !reg_rdata_ff[7]; endproperty
    a_rd_top: assert property (p_rd_top) else $error("gain top bit set");
    c_irq: cover property (protect_irq_req_ff);
    c_raw: cover property (en_ff && raw_compare_out_ff);
    c_dbl: cover property (gd_ff[6] && gain_ratio_ff == 7'h08);
endmodule

bind overcurrent_protect_ctrl protect_sva u_sva (.*);

/* bench/test_overcurrent_protect_ctrl.sv */
`timescale 1ns/100ps
`include "protect_defines.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module test_overcurrent_protect_ctrl;
    localparam [5:0]  OFFS   = 6'h0D;
    localparam [55:0] RATIOS = {7'h41, 7'h28, 7'h19, 7'h0F, 7'h0A, 7'h06, 7'h04, 7'h01};
    localparam [63:0] RST    = 64'h00102000000000C8;
    localparam [63:0] MSK    = 64'h007FFFFFF37F00FF;
    reg        clk = 1'b0;
    reg        srst = 1'b1;
    reg        reg_wr = 1'b0;
    reg        reg_rd = 1'b0;
    reg  [2:0] reg_addr = 3'h0;
    reg  [7:0] reg_wdata = 8'h00;
    reg  [7:0] sense = 8'h00;
    reg  [7:0] d;
    reg        last;
    integer    n_fail = 0, checks_done = 0, cyc = 0, n_irq = 0, n0, c, i;
    wire       comparator_in;
    wire [7:0] reg_rdata_ff, analog_switch_bits_ff, dac_code_ff;
    wire [7:0] gain_ratio_ff;
    wire [5:0] amp_trim_value_ff;
    wire [4:0] comparator_trim_value_ff;
    wire [2:0] current_input_en_ff;
    wire       unity_buffer_ff, dac_reference_sel_ff, comparator_hysteresis_en_ff, comparator_input_sel_ff;
    wire       voltage_input_en_ff, amp_output_en_ff, comparator_output_en_ff, amp_trim_mode_ff;
    wire       amp_trim_ref_sel_ff, comparator_trim_mode_ff, comparator_trim_ref_sel_ff, raw_compare_out_ff;
    wire       debounced_compare_out_ff, protect_irq_signal_ff, protect_irq_req_ff;
    overcurrent_protect_ctrl u_dut (.*);
    analog_side_model #(.AMP_OFFS(OFFS)) u_ana (.clk(clk), .trim_mode(amp_trim_mode_ff),
        .trim_value(amp_trim_value_ff), .dac_code(dac_code_ff), .sense_level(sense), .cmp_out(comparator_in));
    always #2.5 clk = ~clk;
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (protect_irq_req_ff === 1'b1) n_irq = n_irq + 1;
        if (cyc == 20000) begin n_fail = n_fail + 1; test_done; end
    end
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // one idle cycle after each strobe keeps a strobe from being assigned twice in one step
    task wr(input [2:0] a, input [7:0] v);
        begin
            reg_addr <= a;
            reg_wdata <= v;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
            tick(1);
        end
    endtask
    task rd(input [2:0] a, output [7:0] v);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 v = reg_rdata_ff;
            tick(1);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 8; i = i + 1) begin
            rd(i[2:0], d);
            `CHK(d, RST[i*8 +: 8])
        end
        for (i = 0; i < 8; i = i + 1) if (i != 1) wr(i[2:0], 8'hFF);
        for (i = 0; i < 8; i = i + 1) begin
            rd(i[2:0], d);
            `CHK(d, MSK[i*8 +: 8])
        end
        `CHK({voltage_input_en_ff, current_input_en_ff, amp_output_en_ff, comparator_output_en_ff}, 6'h00)
        wr(`REG_ENPOL, 8'h80);
        tick(2);
        `CHK({voltage_input_en_ff, current_input_en_ff, amp_output_en_ff, comparator_output_en_ff}, 6'h3F)
        wr(`REG_SWITCH, 8'h8F);
        `CHK({unity_buffer_ff, analog_switch_bits_ff}, 9'h18F)
        for (i = 0; i < 8; i = i + 1) begin
            wr(`REG_GAINDEB, {2'h0, i[2:0], 3'h0});
            `CHK(gain_ratio_ff, RATIOS[i*7 +: 7])
        end
        wr(`REG_GAINDEB, 8'h48);
        `CHK(gain_ratio_ff, 7'h08)
        wr(`REG_GAINDEB, 8'h78);
        `CHK(gain_ratio_ff, 8'h82)
        wr(`REG_SWITCH, 8'h28);
        wr(`REG_AMPTRIM, 8'hC0);
        wr(`REG_CMPTRIM, 8'h10);
        wr(`REG_DAC, 8'h40);
        `CHK(dac_code_ff, 8'h40)
        tick(3);
        rd(`REG_CMPTRIM, d);
        last = d[7];
        c = 0;
        while (c < 63 && d[7] === last) begin
            c = c + 1;
            wr(`REG_AMPTRIM, 8'hC0 | c[7:0]);
            tick(3);
            rd(`REG_CMPTRIM, d);
        end
        `CHK({amp_trim_mode_ff, amp_trim_ref_sel_ff, amp_trim_value_ff}, {2'h3, OFFS})
        wr(`REG_SWITCH, 8'h28);
        wr(`REG_CMPTRIM, 8'h50);
        wr(`REG_AMPTRIM, 8'h20);
        `CHK({comparator_trim_mode_ff, comparator_trim_ref_sel_ff, comparator_trim_value_ff}, 7'h50)
        tick(140);
        n0 = n_irq;
        for (i = 0; i < 8; i = i + 1) begin
            wr(`REG_GAINDEB, i[7:0]);
            tick(140);
            sense <= 8'hFF;
            c = 0;
            while (c < 300 && debounced_compare_out_ff !== 1'b1) begin
                tick(1);
                c = c + 1;
            end
            `CHK(c >= 2 + (1 << i) && c <= 4 + (1 << i), 1'b1)
            sense <= 8'h00;
        end
        wr(`REG_ENPOL, 8'hD3);
        `CHK({comparator_hysteresis_en_ff, comparator_input_sel_ff, dac_reference_sel_ff}, 3'h7)
        wr(`REG_GAINDEB, 8'h03);
        tick(140);
        `CHK(n_irq - n0, 9)
        sense <= 8'hFF;
        tick(4);
        sense <= 8'h00;
        tick(20);
        `CHK(debounced_compare_out_ff, 1'b0)
        test_done;
    end
endmodule
